/* File: rtl/flash_pin_map.svh */
// Frame lengths, lane masks, timing figures and default opcodes of the serial flash pin interface.
`ifndef FLASH_PIN_MAP_SVH
`define FLASH_PIN_MAP_SVH

`define CLK_PERIOD_PS       8000
`define RESET_PULSE_MIN_NS  100
`define INIT_TIME_NS        300000
`define ADDR_BYTES          3
`define DUMMY_CYCLES        8

`define OP_READ             8'h10
`define OP_FAST_READ        8'h11
`define OP_DUAL_OUT         8'h12
`define OP_QUAD_OUT         8'h13
`define OP_DUAL_IO          8'h14
`define OP_QUAD_IO          8'h15
`define OP_QUAD_IO_DDR      8'h16
`define OP_REG_WRITE        8'h17

`define MASK_OUT_1          4'h2
`define MASK_OUT_2          4'h3
`define MASK_OUT_4          4'hF

`endif

/* File: rtl/flash_pin_pkg.sv */
// Types shared by the serial flash pin interface.
package flash_pin_pkg;

	typedef enum logic [2:0] {
		ST_INSTR,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA_IN,
		ST_DATA_OUT,
		ST_IGNORE
	} link_state_t;

	typedef enum logic [1:0] {
		LANE_1,
		LANE_2,
		LANE_4
	} lane_t;

	typedef enum logic [1:0] {
		SY_INIT,
		SY_READY,
		SY_RESET
	} sys_state_t;

	typedef struct packed {
		lane_t in_w;
		lane_t out_w;
		logic  addr;
		logic  dummy;
		logic  out;
		logic  ddr;
		logic  reg_wr;
		logic  quad;
	} cmd_t;

	typedef struct packed {
		logic       first;
		logic       reg_wr;
		logic [7:0] data;
	} rx_t;

	typedef struct packed {
		logic clear_volatile;
		logic bank_zero;
		logic buffer_ones;
		logic reload;
	} reset_fx_t;

endpackage : flash_pin_pkg

/* File: rtl/flash_pin_if.sv */
// Pin-level interface logic of a serial NOR flash: lanes, edges, select, reset, protect, pause.
`timescale 1ns/1ps
`include "flash_pin_map.svh"

// Operation
// - Single-bit commands: host sends on SI only, device answers on SO only.
// - Dual/quad output: command on SI, data back on IO0-1 or IO0-3.
// - Dual/quad I/O: host sends on 2 or 4 lanes, device answers alike.
// - Reset pin low for minimum time aborts work, tristates outputs, idles control.
// - Hardware reset clears volatile bits, zeroes bank, fills buffer, reloads config.
// - Hardware reset runs power-up initialization, lasting init time before commands.
// - Reset pin assertion is honoured at any moment, even mid-command.
// - Inputs sampled on rising clock; outputs change after falling (SDR) or every edge (DDR).
// - Chip select high: inputs ignored, all outputs high impedance.
// - Select high and no embedded work means standby; select low means active.
// - After power-up, a chip select falling edge is needed before any command.
// - Register write refused when write disable set and protect pin low.
// - Quad enable turns the protect pin into bidirectional lane IO2.
// - Pause starts at pause pin fall if clock low, else next clock low.
// - Pause ends at pause pin rise if clock low, else next clock low.
// - While paused, SO is high impedance and SI and clock are ignored.
// - Pausing never stops an embedded write, program or erase.
// - Select high during pause resets the interface; restart needs pause pin high.
// - Quad enable turns the pause pin into bidirectional lane IO3.
// - SI becomes IO0: receives on rising edges, drives read data per rate.
// - SO becomes IO1: receives on rising edges, drives read data per rate.
// - Every command opens with 8 instruction bits on SI, MSB first.
// - In lane groups the LSB is on IO0, higher bits on higher lanes.
module flash_pin_if #(
	parameter int unsigned CLK_PERIOD_PS  = `CLK_PERIOD_PS,
	parameter int unsigned RESET_PULSE_CYCLES =
		(`RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
	parameter int unsigned INIT_CYCLES    =
		(`INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
	parameter int unsigned ADDR_BYTES     = `ADDR_BYTES,
	parameter int unsigned DUMMY_CYCLES   = `DUMMY_CYCLES,
	parameter logic [7:0]  OP_READ        = `OP_READ,
	parameter logic [7:0]  OP_FAST_READ   = `OP_FAST_READ,
	parameter logic [7:0]  OP_DUAL_OUT    = `OP_DUAL_OUT,
	parameter logic [7:0]  OP_QUAD_OUT    = `OP_QUAD_OUT,
	parameter logic [7:0]  OP_DUAL_IO     = `OP_DUAL_IO,
	parameter logic [7:0]  OP_QUAD_IO     = `OP_QUAD_IO,
	parameter logic [7:0]  OP_QUAD_IO_DDR = `OP_QUAD_IO_DDR,
	parameter logic [7:0]  OP_REG_WRITE   = `OP_REG_WRITE
) (
	input  wire logic                    CLOCK_I,
	input  wire logic                    RESET_N_I,
	input  wire logic                    SCK_I,
	input  wire logic                    CS_N_I,
	input  wire logic                    FLASH_RESET_N_I,
	input  wire logic [3:0]              IO_I,
	output logic [3:0]                   IO_O,
	output logic [3:0]                   IO_OE_O,
	input  wire logic                    QUAD_ENABLE_I,
	input  wire logic                    STATUS_WRITE_DISABLE_I,
	input  wire logic                    EMBEDDED_BUSY_I,
	input  wire logic [7:0]              TX_DATA_I,
	output logic                         TX_TAKE_O,
	output flash_pin_pkg::rx_t           RX_O,
	output logic                         RX_VALID_O,
	output logic                         REG_WRITE_REFUSED_O,
	output logic                         PROTECT_LOCK_O,
	output logic                         READY_O,
	output logic                         POWER_ACTIVE_O,
	output logic                         POWER_STANDBY_O,
	output flash_pin_pkg::reset_fx_t     RESET_EFFECTS_O
);

	function automatic logic [3:0] lane_bits(flash_pin_pkg::lane_t w);
		case (w)
			flash_pin_pkg::LANE_2: lane_bits = 4'h2;
			flash_pin_pkg::LANE_4: lane_bits = 4'h4;
			default:               lane_bits = 4'h1;
		endcase
	endfunction : lane_bits

	// Lowest lane carries the least significant bit of each group.
	function automatic logic [7:0] shift_in(logic [7:0] s, flash_pin_pkg::lane_t w,
						logic [3:0] io);
		case (w)
			flash_pin_pkg::LANE_2: shift_in = {s[5:0], io[1:0]};
			flash_pin_pkg::LANE_4: shift_in = {s[3:0], io[3:0]};
			default:               shift_in = {s[6:0], io[0]};
		endcase
	endfunction : shift_in

	function automatic logic [3:0] group_out(logic [7:0] b, flash_pin_pkg::lane_t w,
						 logic [2:0] s);
		logic [7:0] sh;
		sh = 8'h00;
		case (w)
			flash_pin_pkg::LANE_2: begin
				sh = b << {s[1:0], 1'b0};
				group_out = {2'b00, sh[7:6]};
			end
			flash_pin_pkg::LANE_4: begin
				sh = b << {s[0], 2'b00};
				group_out = sh[7:4];
			end
			default: begin
				sh = b << s;
				group_out = {2'b00, sh[7], 1'b0};
			end
		endcase
	endfunction : group_out

	function automatic logic [3:0] out_mask(flash_pin_pkg::lane_t w);
		case (w)
			flash_pin_pkg::LANE_2: out_mask = `MASK_OUT_2;
			flash_pin_pkg::LANE_4: out_mask = `MASK_OUT_4;
			default:               out_mask = `MASK_OUT_1;
		endcase
	endfunction : out_mask

	function automatic flash_pin_pkg::cmd_t decode(logic [7:0] op);
		flash_pin_pkg::cmd_t c;
		c = '{in_w: flash_pin_pkg::LANE_1, out_w: flash_pin_pkg::LANE_1,
		      addr: 1'b0, dummy: 1'b0, out: 1'b0, ddr: 1'b0, reg_wr: 1'b0, quad: 1'b0};
		if (op == OP_READ) begin
			c.addr = 1'b1;
			c.out  = 1'b1;
		end else if (op == OP_FAST_READ) begin
			c.addr  = 1'b1;
			c.dummy = 1'b1;
			c.out   = 1'b1;
		end else if (op == OP_DUAL_OUT || op == OP_QUAD_OUT) begin
			c.addr  = 1'b1;
			c.dummy = 1'b1;
			c.out   = 1'b1;
			c.quad  = (op == OP_QUAD_OUT);
			c.out_w = c.quad ? flash_pin_pkg::LANE_4 : flash_pin_pkg::LANE_2;
		end else if (op == OP_DUAL_IO || op == OP_QUAD_IO || op == OP_QUAD_IO_DDR) begin
			c.addr  = 1'b1;
			c.dummy = 1'b1;
			c.out   = 1'b1;
			c.quad  = (op != OP_DUAL_IO);
			c.ddr   = (op == OP_QUAD_IO_DDR);
			c.in_w  = c.quad ? flash_pin_pkg::LANE_4 : flash_pin_pkg::LANE_2;
			c.out_w = c.in_w;
		end else if (op == OP_REG_WRITE) begin
			c.reg_wr = 1'b1;
		end
		decode = c;
	endfunction : decode

	// System clock domain.
	flash_pin_pkg::sys_state_t sys_q;
	logic [31:0]               low_cnt_q;
	logic [31:0]               init_cnt_q;
	logic                      rpin_s1_q, rpin_s2_q;
	logic                      cs_s1_q, cs_s2_q;
	logic                      wp_s1_q, wp_s2_q;
	logic                      rxt_s1_q, rxt_s2_q, rxt_s3_q;
	logic                      txt_s1_q, txt_s2_q, txt_s3_q;
	logic                      armed_q;
	logic                      take_q, load_q;
	logic [7:0]                tx_hold_q;
	logic                      trigger;
	logic                      lock;

	// Link clock domain.
	flash_pin_pkg::link_state_t state_q;
	flash_pin_pkg::cmd_t        cmd_q;
	flash_pin_pkg::cmd_t        dec_now;
	flash_pin_pkg::rx_t         rx_hold_q;
	flash_pin_pkg::lane_t       width_now;
	logic [7:0]                 shift_q;
	logic [3:0]                 bitc_q;
	logic [7:0]                 bytec_q;
	logic                       qe_s1_q, qe_s2_q;
	logic                       pause_q;
	logic                       pause_in;
	logic                       pause_eff;
	logic                       rx_tog_q, tx_tog_q;
	logic [7:0]                 tx_cur_q;
	logic [2:0]                 wsl_q;
	logic [2:0]                 wsl_prev;
	logic [3:0]                 n_q, p_q, oe_q;
	logic [7:0]                 in_byte;
	logic [3:0]                 bits_next;
	logic                       byte_done;
	logic                       drive_now;
	logic                       take_now;
	logic                       rst_link, rst_arm;

	// The pin is sampled at reset as high, like its pull-up leaves it when unconnected.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rpin_s1_q <= 1'b1;
			rpin_s2_q <= 1'b1;
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			wp_s1_q   <= 1'b1;
			wp_s2_q   <= 1'b1;
		end else begin
			rpin_s1_q <= FLASH_RESET_N_I;
			rpin_s2_q <= rpin_s1_q;
			cs_s1_q   <= CS_N_I;
			cs_s2_q   <= cs_s1_q;
			wp_s1_q   <= IO_I[2];
			wp_s2_q   <= wp_s1_q;
		end
	end

	assign trigger = !rpin_s2_q && (low_cnt_q == 32'(RESET_PULSE_CYCLES - 1));

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			low_cnt_q <= 32'h0000_0000;
		end else if (rpin_s2_q) begin
			low_cnt_q <= 32'h0000_0000;
		end else if (low_cnt_q != 32'hFFFF_FFFF) begin
			low_cnt_q <= low_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sys_q      <= flash_pin_pkg::SY_INIT;
			init_cnt_q <= 32'h0000_0000;
		end else if (trigger) begin
			sys_q      <= flash_pin_pkg::SY_RESET;
			init_cnt_q <= 32'h0000_0000;
		end else begin
			case (sys_q)
				flash_pin_pkg::SY_RESET: begin
					if (rpin_s2_q) begin
						sys_q <= flash_pin_pkg::SY_INIT;
					end
				end
				flash_pin_pkg::SY_INIT: begin
					init_cnt_q <= init_cnt_q + 32'h0000_0001;
					if (init_cnt_q == 32'(INIT_CYCLES - 1)) begin
						sys_q <= flash_pin_pkg::SY_READY;
					end
				end
				default: sys_q <= flash_pin_pkg::SY_READY;
			endcase
		end
	end

	// Arming only happens while select is high, so the arm reset is always released
	// with select high and the first command needs a fresh select fall.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			armed_q <= 1'b0;
		end else if (sys_q != flash_pin_pkg::SY_READY || trigger) begin
			armed_q <= 1'b0;
		end else if (cs_s2_q) begin
			armed_q <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RESET_EFFECTS_O <= '0;
			READY_O         <= 1'b0;
			POWER_ACTIVE_O  <= 1'b0;
			POWER_STANDBY_O <= 1'b0;
		end else begin
			RESET_EFFECTS_O <= {4{trigger}};
			READY_O         <= armed_q;
			POWER_ACTIVE_O  <= !cs_s2_q;
			// The pause pin plays no part here, so embedded work keeps running.
			POWER_STANDBY_O <= cs_s2_q && !EMBEDDED_BUSY_I;
		end
	end

	assign lock = STATUS_WRITE_DISABLE_I && !wp_s2_q && !QUAD_ENABLE_I;

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rxt_s1_q            <= 1'b0;
			rxt_s2_q            <= 1'b0;
			rxt_s3_q            <= 1'b0;
			RX_O                <= '0;
			RX_VALID_O          <= 1'b0;
			REG_WRITE_REFUSED_O <= 1'b0;
			PROTECT_LOCK_O      <= 1'b0;
		end else begin
			rxt_s1_q            <= rx_tog_q && armed_q;
			rxt_s2_q            <= rxt_s1_q && armed_q;
			rxt_s3_q            <= rxt_s2_q && armed_q;
			RX_VALID_O          <= rxt_s2_q ^ rxt_s3_q;
			REG_WRITE_REFUSED_O <= (rxt_s2_q ^ rxt_s3_q) && rx_hold_q.reg_wr &&
					       !rx_hold_q.first && lock;
			PROTECT_LOCK_O      <= lock;
			if (rxt_s2_q ^ rxt_s3_q) begin
				RX_O <= rx_hold_q;
			end
		end
	end

	// Read bytes: the core advances on TX_TAKE_O and the new byte is latched two cycles on.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			txt_s1_q  <= 1'b0;
			txt_s2_q  <= 1'b0;
			txt_s3_q  <= 1'b0;
			take_q    <= 1'b0;
			load_q    <= 1'b0;
			tx_hold_q <= 8'h00;
		end else begin
			txt_s1_q <= tx_tog_q && armed_q;
			txt_s2_q <= txt_s1_q && armed_q;
			txt_s3_q <= txt_s2_q && armed_q;
			take_q   <= txt_s2_q ^ txt_s3_q;
			load_q   <= take_q;
			if (load_q || cs_s2_q) begin
				tx_hold_q <= TX_DATA_I;
			end
		end
	end

	assign TX_TAKE_O = take_q;

	// Link logic.
	assign rst_link = CS_N_I || !armed_q;
	assign rst_arm  = !armed_q;

	// Sampled at the rising edge the pin shows the pause state that held while clock was low.
	assign pause_in  = !IO_I[3] && !qe_s2_q;
	assign pause_eff = SCK_I ? pause_q : pause_in;

	assign width_now = (state_q == flash_pin_pkg::ST_INSTR) ? flash_pin_pkg::LANE_1
								 : cmd_q.in_w;
	assign in_byte   = shift_in(shift_q, width_now, IO_I);
	assign dec_now   = decode(in_byte);
	assign bits_next = bitc_q + lane_bits(width_now);
	assign byte_done = !pause_in && (bits_next == 4'h8) &&
			   (state_q == flash_pin_pkg::ST_INSTR || state_q == flash_pin_pkg::ST_ADDR ||
			    state_q == flash_pin_pkg::ST_DATA_IN);

	always_ff @(posedge SCK_I or posedge rst_link) begin
		if (rst_link) begin
			qe_s1_q <= 1'b0;
			qe_s2_q <= 1'b0;
		end else begin
			qe_s1_q <= QUAD_ENABLE_I;
			qe_s2_q <= qe_s1_q;
		end
	end

	always_ff @(posedge SCK_I or posedge rst_link) begin
		if (rst_link) begin
			state_q <= flash_pin_pkg::ST_INSTR;
			cmd_q   <= '0;
			shift_q <= 8'h00;
			bitc_q  <= 4'h0;
			bytec_q <= 8'h00;
		end else if (!pause_in) begin
			case (state_q)
				flash_pin_pkg::ST_INSTR,
				flash_pin_pkg::ST_ADDR,
				flash_pin_pkg::ST_DATA_IN: begin
					shift_q <= in_byte;
					bitc_q  <= byte_done ? 4'h0 : bits_next;
					if (byte_done && state_q == flash_pin_pkg::ST_INSTR) begin
						cmd_q <= dec_now;
						if (dec_now.quad && !qe_s2_q) begin
							state_q <= flash_pin_pkg::ST_IGNORE;
						end else if (dec_now.addr) begin
							state_q <= flash_pin_pkg::ST_ADDR;
						end else if (dec_now.out) begin
							state_q <= flash_pin_pkg::ST_DATA_OUT;
						end else begin
							state_q <= flash_pin_pkg::ST_DATA_IN;
						end
					end else if (byte_done && state_q == flash_pin_pkg::ST_ADDR) begin
						bytec_q <= bytec_q + 8'h01;
						if (bytec_q == 8'(ADDR_BYTES - 1)) begin
							state_q <= cmd_q.dummy ? flash_pin_pkg::ST_DUMMY :
								   flash_pin_pkg::ST_DATA_OUT;
						end
					end
				end
				flash_pin_pkg::ST_DUMMY: begin
					bitc_q <= bitc_q + 4'h1;
					if (bitc_q == 4'(DUMMY_CYCLES - 1)) begin
						state_q <= flash_pin_pkg::ST_DATA_OUT;
					end
				end
				default: state_q <= state_q;
			endcase
		end
	end

	// Toggles survive select going high so the system side never sees a false event.
	always_ff @(posedge SCK_I or posedge rst_arm) begin
		if (rst_arm) begin
			rx_tog_q  <= 1'b0;
			rx_hold_q <= '0;
		end else if (byte_done && !CS_N_I) begin
			rx_tog_q  <= !rx_tog_q;
			rx_hold_q <= '{first: (state_q == flash_pin_pkg::ST_INSTR),
				       reg_wr: cmd_q.reg_wr, data: in_byte};
		end
	end

	// SDR data and the first DDR slot of each clock change after the falling edge.
	assign drive_now = (state_q == flash_pin_pkg::ST_DATA_OUT) && !pause_in;
	assign take_now  = drive_now && (wsl_q == 3'h0) && !CS_N_I;

	always_ff @(negedge SCK_I or posedge rst_link) begin
		if (rst_link) begin
			pause_q  <= 1'b0;
			n_q      <= 4'h0;
			oe_q     <= 4'h0;
			wsl_q    <= 3'h0;
			tx_cur_q <= 8'h00;
		end else begin
			pause_q <= pause_in;
			if (drive_now) begin
				n_q  <= group_out((wsl_q == 3'h0) ? tx_hold_q : tx_cur_q,
						  cmd_q.out_w, wsl_q);
				oe_q <= out_mask(cmd_q.out_w);
				if (wsl_q == 3'h0) begin
					tx_cur_q <= tx_hold_q;
				end
				if (wsl_q + (cmd_q.ddr ? 3'h2 : 3'h1) ==
				    3'(4'h8 / lane_bits(cmd_q.out_w))) begin
					wsl_q <= 3'h0;
				end else begin
					wsl_q <= wsl_q + (cmd_q.ddr ? 3'h2 : 3'h1);
				end
			end else if (state_q != flash_pin_pkg::ST_DATA_OUT) begin
				oe_q <= 4'h0;
			end
		end
	end

	always_ff @(negedge SCK_I or posedge rst_arm) begin
		if (rst_arm) begin
			tx_tog_q <= 1'b0;
		end else if (take_now) begin
			tx_tog_q <= !tx_tog_q;
		end
	end

	assign wsl_prev = ((wsl_q == 3'h0) ? 3'(4'h8 / lane_bits(cmd_q.out_w)) : wsl_q) - 3'h1;

	// Second DDR slot of each clock goes out after the rising edge.
	always_ff @(posedge SCK_I or posedge rst_link) begin
		if (rst_link) begin
			p_q <= 4'h0;
		end else if (cmd_q.ddr && drive_now) begin
			p_q <= group_out(tx_cur_q, cmd_q.out_w, wsl_prev);
		end
	end

	assign IO_O    = (cmd_q.ddr && SCK_I) ? p_q : n_q;
	assign IO_OE_O = oe_q & {4{!pause_eff}};

endmodule : flash_pin_if

/* File: verif/flash_pin_if_properties.sv */
// Port-level assertions for the serial flash pin interface.
`timescale 1ns/1ps
module flash_pin_if_properties #(
	parameter int unsigned INIT_CYCLES = 20
) (
	input wire logic                     CLOCK_I,
	input wire logic                     RESET_N_I,
	input wire logic                     SCK_I,
	input wire logic                     CS_N_I,
	input wire logic                     FLASH_RESET_N_I,
	input wire logic [3:0]               IO_I,
	input wire logic [3:0]               IO_OE_O,
	input wire logic                     QUAD_ENABLE_I,
	input wire logic                     STATUS_WRITE_DISABLE_I,
	input wire logic                     EMBEDDED_BUSY_I,
	input wire flash_pin_pkg::rx_t       RX_O,
	input wire logic                     RX_VALID_O,
	input wire logic                     REG_WRITE_REFUSED_O,
	input wire logic                     PROTECT_LOCK_O,
	input wire logic                     READY_O,
	input wire logic                     POWER_STANDBY_O,
	input wire flash_pin_pkg::reset_fx_t RESET_EFFECTS_O
);
	logic [15:0] wait_q;
	// Restarts on every reset so an early ready rise is caught after power-up and pin reset.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) wait_q <= 16'h0000;
		else if (RESET_EFFECTS_O.reload) wait_q <= 16'h0000;
		else if (wait_q != 16'hFFFF) wait_q <= wait_q + 16'h0001;
	end
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);
	property p_cs_hiz; CS_N_I [*4] |-> IO_OE_O == 4'h0; endproperty
	a_cs_hiz: assert property (p_cs_hiz) else $error("lanes driven while deselected");
	property p_standby; (CS_N_I && !EMBEDDED_BUSY_I) [*5] |-> POWER_STANDBY_O; endproperty
	a_standby: assert property (p_standby) else $error("standby missing");
	property p_hw_abort; !FLASH_RESET_N_I [*8] |=> !READY_O && IO_OE_O == 4'h0; endproperty
	a_hw_abort: assert property (p_hw_abort) else $error("pin reset not honoured");
	property p_fx; RESET_EFFECTS_O != 4'h0 |-> RESET_EFFECTS_O == 4'hF ##1 RESET_EFFECTS_O == 4'h0;
	endproperty
	a_fx: assert property (p_fx) else $error("reset effects not one whole pulse");
	property p_init; $rose(READY_O) |-> wait_q >= INIT_CYCLES; endproperty
	a_init: assert property (p_init) else $error("ready before init time");
	property p_rx_ready; RX_VALID_O |-> READY_O; endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("byte taken while not ready");
	property p_refuse;
		REG_WRITE_REFUSED_O |-> RX_VALID_O && RX_O.reg_wr && !RX_O.first && STATUS_WRITE_DISABLE_I;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refusal without cause");
	property p_lock; (STATUS_WRITE_DISABLE_I && !IO_I[2] && !QUAD_ENABLE_I) [*4] |-> PROTECT_LOCK_O;
	endproperty
	a_lock: assert property (p_lock) else $error("protect lock missing");
	property p_pause; (!CS_N_I && !QUAD_ENABLE_I && !IO_I[3] && !SCK_I) [*4] |-> !IO_OE_O[1];
	endproperty
	a_pause: assert property (p_pause) else $error("output driven while paused");
	c_fx: cover property (RESET_EFFECTS_O == 4'hF);
	c_refuse: cover property (REG_WRITE_REFUSED_O);
	c_first: cover property (RX_VALID_O && RX_O.first);
endmodule : flash_pin_if_properties
bind flash_pin_if flash_pin_if_properties #(.INIT_CYCLES(INIT_CYCLES)) flash_pin_if_properties_i (.*);

/* File: verif/host_model.sv */
// Bus master model: mode 0 clock, select and up to four data lanes.
`timescale 1ns/1ps
module host_model (
	input  wire logic [3:0] io_i,
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      io_o,
	output logic [3:0]      io_oe_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'hF;
		io_oe_o = 4'h0;
	end
	// Select moves only with the clock low, so each frame opens on a falling select.
	task automatic sel(input logic on);
		#40;
		cs_n_o = ~on;
		if (!on) io_oe_o[1:0] = 2'b00;
		#40;
	endtask : sel
	task automatic side(input logic wp, input logic hold);
		io_o[3:2] = {hold, wp};
		io_oe_o[3:2] = 2'b11;
	endtask : side
	// Groups go MSB first with the group LSB on IO0; input is sampled before each rise,
	// where the device output has settled.
	task automatic xfer(input logic [7:0] b, input int w, input logic drv, output logic [7:0] r);
		int n;
		for (int g = 0; g < 8 / w; g++) begin
			for (int k = 0; k < w; k++) begin
				n = 8 - (g + 1) * w + k;
				io_o[k] = b[n];
				io_oe_o[k] = drv;
			end
			#40;
			for (int k = 0; k < w; k++) begin
				n = 8 - (g + 1) * w + k;
				r[n] = (w == 1) ? io_i[1] : io_i[k];
			end
			sck_o = 1'b1;
			#40;
			sck_o = 1'b0;
		end
	endtask : xfer
	task automatic ddr(output logic [7:0] r);
		#40;
		r[7:4] = io_i;
		sck_o = 1'b1;
		#40;
		r[3:0] = io_i;
		sck_o = 1'b0;
	endtask : ddr
	task automatic tick(input int n);
		repeat (n) begin
			io_o[0] = ~io_o[0];
			io_oe_o[0] = 1'b1;
			#40;
			sck_o = 1'b1;
			#40;
			sck_o = 1'b0;
		end
	endtask : tick
endmodule : host_model

/* File: verif/test_flash_pin_if.sv */
// Self-checking bench for the serial flash pin interface.
`timescale 1ns/1ps
module test_flash_pin_if;
	logic                     clk, rst_n, frst_n, tog;
	logic                     qe, swd, busy;
	logic                     sck, cs_n, take, rx_v, refused, lock, ready, act, stby;
	logic [7:0]               tx;
	logic [7:0]               r;
	logic [3:0]               h_io, h_oe, d_io, d_oe, pin;
	flash_pin_pkg::rx_t       rx;
	flash_pin_pkg::reset_fx_t fx;
	logic [10:0]              rxq[$];
	int                       fx_n = 0;
	int                       bad_count = 0;
	int                       check_count = 0;
	// Undriven data lanes keep changing; protect and pause lanes are pulled up.
	assign pin = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & {2'b11, tog, tog});
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	flash_pin_if #(.RESET_PULSE_CYCLES(4), .INIT_CYCLES(20)) flash_pin_if_i (
		.CLOCK_I(clk), .RESET_N_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n),
		.FLASH_RESET_N_I(frst_n), .IO_I(pin), .IO_O(d_io), .IO_OE_O(d_oe),
		.QUAD_ENABLE_I(qe), .STATUS_WRITE_DISABLE_I(swd), .EMBEDDED_BUSY_I(busy),
		.TX_DATA_I(tx), .TX_TAKE_O(take), .RX_O(rx), .RX_VALID_O(rx_v),
		.REG_WRITE_REFUSED_O(refused), .PROTECT_LOCK_O(lock), .READY_O(ready),
		.POWER_ACTIVE_O(act), .POWER_STANDBY_O(stby), .RESET_EFFECTS_O(fx)
	);
	host_model host_model_i (.io_i(pin), .sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe));
	always @(posedge clk) begin
		tog <= ~tog;
		if (rx_v === 1'b1) rxq.push_back({refused, rx});
		if (fx === 4'hF) fx_n++;
		if (take === 1'b1) tx <= #1 tx + 8'h11;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic at(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : at
	task automatic pop(input logic [10:0] exp, input logic [10:0] m);
		logic [10:0] v;
		v = 'x;
		if (rxq.size() > 0) v = rxq.pop_front();
		chk("rx byte", 16'(v & m), 16'(exp & m));
	endtask : pop
	task automatic cmd(input logic [7:0] op, input int w, input int n);
		rxq.delete();
		host_model_i.sel(1'b1);
		host_model_i.xfer(op, 1, 1'b1, r);
		for (int i = 1; i <= n; i++) host_model_i.xfer(8'(i), w, 1'b1, r);
	endtask : cmd
	// The reg_wr flag of the instruction byte is left open, so it is masked.
	task automatic rx_chk(input logic [7:0] op, input int n, input logic rf, input logic rw);
		at(6);
		pop({2'b01, 1'b0, op}, 11'h6FF);
		for (int i = 1; i <= n; i++) pop({rf, 1'b0, rw, 8'(i)}, 11'h7FF);
	endtask : rx_chk
	task automatic wait_ready();
		for (int i = 0; i < 100 && ready !== 1'b1; i++) at(1);
		chk("ready", 16'(ready), 16'h0001);
	endtask : wait_ready
	task automatic done(input string name);
		$display("test %s done", name);
	endtask : done
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		rst_n = 1'b0;
		frst_n = 1'b1;
		tog = 1'b0;
		{qe, swd, busy} = 3'b000;
		tx = 8'h00;
		at(2);
		rst_n = 1'b1;
		wait_ready();
		done("power-up");
		tx = 8'hA5;
		cmd(8'h10, 1, 3);
		host_model_i.xfer(8'h00, 1, 1'b0, r);
		chk("read byte 0", 16'(r), 16'h00A5);
		chk("read lanes", 16'(d_oe), 16'h0002);
		host_model_i.side(1'b1, 1'b0);
		at(4);
		chk("paused lanes", 16'(d_oe), 16'h0000);
		host_model_i.tick(2);
		host_model_i.side(1'b1, 1'b1);
		host_model_i.xfer(8'h00, 1, 1'b0, r);
		chk("read byte 1", 16'(r), 16'h00B6);
		host_model_i.sel(1'b0);
		at(4);
		chk("deselected lanes", 16'(d_oe), 16'h0000);
		rx_chk(8'h10, 3, 1'b0, 1'b0);
		done("read");
		qe = 1'b1;
		tx = 8'hC3;
		cmd(8'h16, 4, 3);
		repeat (4) host_model_i.xfer(8'h00, 4, 1'b0, r);
		host_model_i.ddr(r);
		chk("ddr byte 0", 16'(r), 16'h00C3);
		chk("quad lanes", 16'(d_oe), 16'h000F);
		host_model_i.ddr(r);
		chk("ddr byte 1", 16'(r), 16'h00D4);
		host_model_i.sel(1'b0);
		rx_chk(8'h16, 3, 1'b0, 1'b0);
		qe = 1'b0;
		done("quad ddr");
		tx = 8'h5A;
		cmd(8'h14, 2, 3);
		repeat (2) host_model_i.xfer(8'h00, 2, 1'b0, r);
		host_model_i.xfer(8'h00, 2, 1'b0, r);
		chk("dual byte 0", 16'(r), 16'h005A);
		chk("dual lanes", 16'(d_oe), 16'h0003);
		host_model_i.sel(1'b0);
		rx_chk(8'h14, 3, 1'b0, 1'b0);
		done("dual io");
		swd = 1'b1;
		for (int wp = 0; wp < 2; wp++) begin
			host_model_i.side(1'(wp), 1'b1);
			at(6);
			chk("lock", 16'(lock), 16'(1 - wp));
			cmd(8'h17, 1, 1);
			host_model_i.sel(1'b0);
			rx_chk(8'h17, 1, 1'(1 - wp), 1'b1);
		end
		host_model_i.side(1'b0, 1'b1);
		qe = 1'b1;
		at(6);
		chk("lock in quad", 16'(lock), 16'h0000);
		qe = 1'b0;
		swd = 1'b0;
		done("protect");
		host_model_i.side(1'b1, 1'b1);
		host_model_i.sel(1'b1);
		at(6);
		chk("active", 16'(act), 16'h0001);
		host_model_i.sel(1'b0);
		at(6);
		chk("standby", 16'(stby), 16'h0001);
		busy = 1'b1;
		at(6);
		chk("busy standby", 16'(stby), 16'h0000);
		busy = 1'b0;
		done("power");
		cmd(8'h10, 1, 1);
		frst_n = 1'b0;
		at(2);
		frst_n = 1'b1;
		at(20);
		chk("short pulse", 16'(fx_n), 16'h0000);
		frst_n = 1'b0;
		at(8);
		frst_n = 1'b1;
		at(4);
		chk("effects", 16'(fx_n), 16'h0001);
		chk("ready after pin", 16'(ready), 16'h0000);
		chk("aborted lanes", 16'(d_oe), 16'h0000);
		host_model_i.sel(1'b0);
		wait_ready();
		cmd(8'h20, 1, 1);
		host_model_i.sel(1'b0);
		rx_chk(8'h20, 1, 1'b0, 1'b0);
		done("pin reset");
		cmd(8'h20, 1, 0);
		host_model_i.side(1'b1, 1'b0);
		host_model_i.sel(1'b0);
		host_model_i.side(1'b1, 1'b1);
		cmd(8'h21, 1, 1);
		host_model_i.sel(1'b0);
		rx_chk(8'h21, 1, 1'b0, 1'b0);
		done("pause deselect");
		stop_test();
	end
endmodule : test_flash_pin_if
